// ---- verilog/adcc_pkg.sv ----
/*
  Constants for the converter control block: special function register
  addresses, control register field layout, reset values and the
  machine-cycle timing of one conversion.
  Assumes one core clock; a machine cycle is a whole number of clock periods.
*/
`default_nettype none

package adcc_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADCC_ADDR_CTRL     = 8'hc5;
  // result register address is set by a module parameter; this is its default
  localparam logic [7:0] ADCC_ADDR_RES_DFLT = 8'hc6;

  // ----------------------------------------------------------------
  // converter_control_status field positions
  // ----------------------------------------------------------------
  localparam int ADCC_BIT_RES1  = 7;
  localparam int ADCC_BIT_RES0  = 6;
  localparam int ADCC_BIT_SRC   = 5;
  localparam int ADCC_BIT_DONE  = 4;
  localparam int ADCC_BIT_START = 3;
  localparam int ADCC_CH_MSB    = 2;
  localparam int ADCC_CH_LSB    = 0;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int         ADCC_RES_W      = 10;
  localparam int         ADCC_BYTE_W     = 8;
  localparam int         ADCC_CH_W       = 3;
  localparam int         ADCC_NUM_CH     = 6;
  localparam logic [2:0] ADCC_CH_RST     = 3'h0;
  localparam logic [9:0] ADCC_RESULT_RST = 10'h000;
  localparam logic [7:0] ADCC_RDATA_RST  = 8'h00;

  // ----------------------------------------------------------------
  // timing, in machine cycles
  // ----------------------------------------------------------------
  // one machine cycle is 500 ns at the 12 MHz reference, i.e. 6 clocks
  localparam int ADCC_CONV_TIME_NS   = 25000;
  localparam int ADCC_REF_OSC_NS_X12 = 1000;
  localparam int ADCC_FULL_MCYC      = 50;
  localparam int ADCC_BYTE_MCYC      = 24;
  localparam int ADCC_MCYC_CLKS      = (ADCC_CONV_TIME_NS * 12) / (ADCC_FULL_MCYC * ADCC_REF_OSC_NS_X12);
  localparam int ADCC_INIT_MCYC      = 2;
  localparam int ADCC_SAMPLE_MCYC    = 8;
  localparam int ADCC_BIT_MCYC       = 4;
  // byte mode: 2 init + 6 sample + 8 bits x 2 = 24
  localparam int ADCC_BSAMPLE_MCYC   = 6;
  localparam int ADCC_BBIT_MCYC      = 2;

  typedef enum logic [2:0]
  {
    ADCC_S_IDLE,
    ADCC_S_ARM,
    ADCC_S_INIT,
    ADCC_S_SAMPLE,
    ADCC_S_CONV
  } adcc_state_e;

endpackage

`default_nettype wire

// ---- verilog/adcc_sar_step.sv ----
/*
  Successive-approximation register: bit pointer, trial code and the
  comparator decision kept per bit.
  Assumes the caller pulses i_load once per conversion and i_latch at the
  end of every bit step while the comparator output is settled.
*/
`timescale 1ns/1ps
`default_nettype none

module adcc_sar_step
  import adcc_pkg::*;
#(
  parameter int P_RES_W = ADCC_RES_W
)
(
  // clock and reset
  input  wire logic               i_mclk,
  input  wire logic               i_rst_n,
  // control
  input  wire logic               i_load,
  input  wire logic               i_byte_mode,
  input  wire logic               i_latch,
  input  wire logic               i_comp_gt,
  // code
  output logic [P_RES_W-1:0]      o_trial_code,
  output logic                    o_last_bit
);

  logic [P_RES_W-1:0] code_ff;
  logic [P_RES_W-1:0] ptr_ff;
  logic [P_RES_W-1:0] nxt_code;
  logic [P_RES_W-1:0] last_ptr;

  // byte mode stops two bits early; the low bits stay zero
  assign last_ptr     = i_byte_mode ? {{(P_RES_W-3){1'b0}}, 3'h4} : {{(P_RES_W-1){1'b0}}, 1'b1};
  assign o_last_bit   = (ptr_ff == last_ptr);
  assign o_trial_code = code_ff;

  // RULE12: keep or clear tested bit
  always_comb
  begin
    nxt_code = code_ff;
    if (!i_comp_gt)
      nxt_code = code_ff & ~ptr_ff;
    nxt_code = nxt_code | (ptr_ff >> 1);
  end

  // RULE25: one decision per step
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      code_ff <= '0;
      ptr_ff  <= '0;
    end
    else if (i_load)
    begin
      code_ff <= {1'b1, {(P_RES_W-1){1'b0}}};
      ptr_ff  <= {1'b1, {(P_RES_W-1){1'b0}}};
    end
    else if (i_latch && (ptr_ff != '0))
    begin
      if (o_last_bit)
        code_ff <= i_comp_gt ? code_ff : (code_ff & ~ptr_ff);
      else
        code_ff <= nxt_code;
      ptr_ff <= ptr_ff >> 1;
    end
  end

endmodule

`default_nettype wire

// ---- verilog/adcc_top.sv ----
/*
  Conversion control for the on-chip successive-approximation converter:
  special function register access, start handling, machine-cycle timing,
  result capture, channel select and low-power behaviour.
  Assumes a byte-wide SFR bus synchronous to i_mclk, and that the auxiliary
  configuration register lives elsewhere and hands over its two bits.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE1: six inputs, 10-bit binary search
// RULE2: byte mode gives 8-bit result
// RULE3: full conversion takes fifty machine cycles
// RULE4: byte mode takes twenty-four cycles
// RULE5: idle keep-alive keeps converter powered
// RULE6: software start bit begins conversion
// RULE7: source select zero means software start; code takes the software start with either source setting
// RULE8: begins at next machine cycle boundary
// RULE9: command flop and separate busy flop
// RULE10: two init cycles, busy after first
// RULE11: eight cycles of input sampling
// RULE12: MSB first, keep bit if above
// RULE13: four machine cycles per bit
// RULE14: high byte and two low bits
// RULE15: done set, busy cleared together
// RULE16: three low bits drive multiplexer
// RULE17: start during conversion is ignored
// RULE18: idle or power-down entry aborts
// RULE19: finished result held while done
// RULE20: unused analog pins stay digital
// RULE21: start blocked while busy or done; code takes a start whose write also clears done
// RULE22: channel writable only when quiet
// RULE23: done requests interrupt, software clears
// RULE24: codes zero to five, pins two-seven
// RULE25: drive trial code, latch comparator
// RULE26: reset leaves converter idle, cleared
module adcc_top
  import adcc_pkg::*;
#(
  parameter int         P_MCYC_CLKS = ADCC_MCYC_CLKS,
  parameter logic [7:0] P_ADDR_RES  = ADCC_ADDR_RES_DFLT
)
(
  // clock and reset
  input  wire logic                       i_mclk,
  input  wire logic                       i_rst_n,
  // sfr bus
  input  wire logic [7:0]                 i_sfr_addr,
  input  wire logic                       i_sfr_wr,
  input  wire logic                       i_sfr_rd,
  input  wire logic [7:0]                 i_sfr_wdata,
  output logic [7:0]                      o_sfr_rdata,
  // auxiliary configuration and power state
  input  wire logic                       i_byte_mode_select,
  input  wire logic                       i_idle_keep_alive,
  input  wire logic                       i_idle_mode,
  input  wire logic                       i_power_down,
  // analog front end
  output logic [ADCC_NUM_CH-1:0]          o_analog_pin_sel,
  output logic                            o_sample_en,
  output logic [ADCC_RES_W-1:0]           o_trial_voltage,
  input  wire logic                       i_comp_gt,
  output logic                            o_analog_power_en,
  // status
  output logic                            o_done_irq_req,
  output logic                            o_busy
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  adcc_state_e            state_ff;
  logic [7:0]             div_ff;
  logic [7:0]             phase_ff;
  logic                   cmd_ff;
  logic                   busy_ff;
  logic                   done_ff;
  logic                   src_ff;
  logic [ADCC_CH_W-1:0]   chan_ff;
  logic [ADCC_RES_W-1:0]  result_ff;
  logic                   byte_ff;
  logic                   idle_d_ff;
  logic                   pd_d_ff;
  logic [7:0]             rdata_ff;

  logic                   mtick;
  logic                   wr_ctrl;
  logic                   start_req;
  logic                   done_clr;
  logic                   powered;
  logic                   abort;
  logic                   sar_load;
  logic                   sar_latch;
  logic                   sar_last;
  logic                   finish;
  logic [7:0]             sample_len;
  logic [7:0]             bit_len;
  logic [ADCC_RES_W-1:0]  trial_code;

  // ----------------------------------------------------------------
  // machine cycle divider
  // ----------------------------------------------------------------
  // free running, so a start written mid-cycle waits for the boundary
  assign mtick = (div_ff == 8'(P_MCYC_CLKS - 1));

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      div_ff <= 8'h00;
    else if (mtick)
      div_ff <= 8'h00;
    else
      div_ff <= div_ff + 8'h01;
  end

  // ----------------------------------------------------------------
  // power and abort
  // ----------------------------------------------------------------
  // RULE5: powered in idle only with keep-alive
  assign powered = !i_power_down && !(i_idle_mode && !i_idle_keep_alive);

  // RULE18: entry into low power aborts
  assign abort = (i_idle_mode && !idle_d_ff) || (i_power_down && !pd_d_ff) || !powered;

  assign o_analog_power_en = powered;

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      idle_d_ff <= 1'b0;
      pd_d_ff   <= 1'b0;
    end
    else
    begin
      idle_d_ff <= i_idle_mode;
      pd_d_ff   <= i_power_down;
    end
  end

  // ----------------------------------------------------------------
  // register write decode
  // ----------------------------------------------------------------
  assign wr_ctrl  = i_sfr_wr && (i_sfr_addr == ADCC_ADDR_CTRL);
  // RULE23: software writes zero to clear only
  assign done_clr = wr_ctrl && !i_sfr_wdata[ADCC_BIT_DONE];

  // RULE21: blocked while busy or done
  // clearing done in the same write as setting start is allowed
  // RULE7: both source settings take the software start
  assign start_req = wr_ctrl && i_sfr_wdata[ADCC_BIT_START] && !cmd_ff && !busy_ff &&
                     (!done_ff || done_clr) && powered;

  // RULE9: command flop, set only by writes
  // RULE6: software write sets the command
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      cmd_ff <= 1'b0;
    else if (abort || finish)
      cmd_ff <= 1'b0;
    else if (start_req)
      cmd_ff <= 1'b1;
  end

  // RULE22: channel writable only when quiet
  // RULE16: three low bits pick channel
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      chan_ff <= ADCC_CH_RST;
      src_ff  <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      src_ff <= i_sfr_wdata[ADCC_BIT_SRC];
      if (!done_ff && !busy_ff && !cmd_ff)
        chan_ff <= i_sfr_wdata[ADCC_CH_MSB:ADCC_CH_LSB];
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  // RULE2: byte mode shortens sampling and bit steps
  assign sample_len = byte_ff ? 8'(ADCC_BSAMPLE_MCYC) : 8'(ADCC_SAMPLE_MCYC);
  assign bit_len    = byte_ff ? 8'(ADCC_BBIT_MCYC) : 8'(ADCC_BIT_MCYC);

  assign sar_load  = (state_ff == ADCC_S_SAMPLE) && mtick && (phase_ff == sample_len - 8'h01);
  // RULE13: one decision per bit step
  assign sar_latch = (state_ff == ADCC_S_CONV) && mtick && (phase_ff == bit_len - 8'h01);
  // RULE3: 2 + 8 + 10 x 4 cycles
  // RULE4: 2 + 6 + 8 x 2 cycles
  assign finish    = sar_latch && sar_last && !abort;

  // RULE26: reset leaves sequencer idle
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      state_ff <= ADCC_S_IDLE;
      phase_ff <= 8'h00;
      byte_ff  <= 1'b0;
    end
    else if (abort)
    begin
      state_ff <= ADCC_S_IDLE;
      phase_ff <= 8'h00;
    end
    else
    begin
      case (state_ff)
        ADCC_S_IDLE:
        begin
          // RULE17: new starts ignored once running
          if (start_req)
          begin
            state_ff <= ADCC_S_ARM;
            byte_ff  <= i_byte_mode_select;
          end
        end
        ADCC_S_ARM:
        begin
          // RULE8: first machine cycle boundary starts it
          if (mtick)
          begin
            state_ff <= ADCC_S_INIT;
            phase_ff <= 8'h00;
          end
        end
        ADCC_S_INIT:
        begin
          // RULE10: two initialisation cycles
          if (mtick)
          begin
            if (phase_ff == 8'(ADCC_INIT_MCYC - 1))
            begin
              state_ff <= ADCC_S_SAMPLE;
              phase_ff <= 8'h00;
            end
            else
              phase_ff <= phase_ff + 8'h01;
          end
        end
        ADCC_S_SAMPLE:
        begin
          // RULE11: sampling window
          if (mtick)
          begin
            if (sar_load)
            begin
              state_ff <= ADCC_S_CONV;
              phase_ff <= 8'h00;
            end
            else
              phase_ff <= phase_ff + 8'h01;
          end
        end
        ADCC_S_CONV:
        begin
          if (mtick)
          begin
            if (finish)
              state_ff <= ADCC_S_IDLE;
            if (sar_latch)
              phase_ff <= 8'h00;
            else
              phase_ff <= phase_ff + 8'h01;
          end
        end
        default:
        begin
          state_ff <= ADCC_S_IDLE;
          phase_ff <= 8'h00;
        end
      endcase
    end
  end

  // RULE10: busy reads one after first cycle
  // RULE15: busy drops with done set
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      busy_ff <= 1'b0;
    else if (abort || finish)
      busy_ff <= 1'b0;
    else if ((state_ff == ADCC_S_INIT) && mtick && (phase_ff == 8'h00))
      busy_ff <= 1'b1;
  end

  // RULE15: done at end of conversion
  // hardware set wins over a clear in the same cycle
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      done_ff <= 1'b0;
    else if (finish)
      done_ff <= 1'b1;
    else if (done_clr)
      done_ff <= 1'b0;
  end

  // RULE14: result captured at completion
  // RULE19: untouched until the next completion
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      result_ff <= ADCC_RESULT_RST;
    else if (finish)
    begin
      if (i_comp_gt)
        result_ff <= trial_code;
      else
        result_ff <= trial_code & ~(byte_ff ? 10'h004 : 10'h001);
    end
  end

  // ----------------------------------------------------------------
  // successive approximation register
  // ----------------------------------------------------------------
  // RULE1: binary search over the selected input
  adcc_sar_step #(
    .P_RES_W      (ADCC_RES_W)
  ) u_sar (
    .i_mclk       (i_mclk),
    .i_rst_n      (i_rst_n),
    .i_load       (sar_load && !abort),
    .i_byte_mode  (byte_ff),
    .i_latch      (sar_latch && !abort),
    .i_comp_gt    (i_comp_gt),
    .o_trial_code (trial_code),
    .o_last_bit   (sar_last)
  );

  // RULE25: trial code straight to the DAC
  assign o_trial_voltage = trial_code;
  assign o_sample_en     = (state_ff == ADCC_S_SAMPLE);

  // ----------------------------------------------------------------
  // analog multiplexer
  // ----------------------------------------------------------------
  // RULE24: code n selects analog input n
  // RULE20: only the pin under sampling is analog
  // codes 6 and 7 select nothing, leaving all pins digital
  genvar g;
  generate
    for (g = 0; g < ADCC_NUM_CH; g++)
    begin : g_pin
      assign o_analog_pin_sel[g] = o_sample_en && (chan_ff == ADCC_CH_W'(g));
    end
  endgenerate

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // RULE9: start bit reads the busy flop
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      rdata_ff <= ADCC_RDATA_RST;
    else if (i_sfr_rd && (i_sfr_addr == ADCC_ADDR_CTRL))
      rdata_ff <= {result_ff[1:0], src_ff, done_ff, busy_ff, chan_ff};
    else if (i_sfr_rd && (i_sfr_addr == P_ADDR_RES))
      rdata_ff <= result_ff[ADCC_RES_W-1:ADCC_RES_W-ADCC_BYTE_W];
    else if (i_sfr_rd)
      rdata_ff <= ADCC_RDATA_RST;
  end

  assign o_sfr_rdata    = rdata_ff;
  // RULE23: done flag is the request
  assign o_done_irq_req = done_ff;
  assign o_busy         = busy_ff;

endmodule

`default_nettype wire

// ---- dv/adcc_props.sv ----
/*
  port checker for adcc_top.
  assumes byte mode is held steady through each conversion.
*/
`timescale 1ns/1ps
`default_nettype none

module adcc_props #(
  parameter int P_MCYC_CLKS = 6
)
(
  // clock and reset
  input wire logic       i_mclk,
  input wire logic       i_rst_n,
  // watched ports
  input wire logic [7:0] i_sfr_addr,
  input wire logic       i_sfr_rd,
  input wire logic       i_byte_mode_select,
  input wire logic       i_idle_mode,
  input wire logic       i_power_down,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic [5:0] o_analog_pin_sel,
  input wire logic       o_sample_en,
  input wire logic [9:0] o_trial_voltage,
  input wire logic       o_analog_power_en,
  input wire logic       o_done_irq_req,
  input wire logic       o_busy
);
  logic [9:0] busy_cnt_ff;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  // ----------------------------------------------------------------
  // busy length counter
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    busy_cnt_ff <= (!i_rst_n || !o_busy) ? 10'h000 : busy_cnt_ff + 10'h001;
  end

  conv_time_a: assert property ($rose(o_done_irq_req) |->
    busy_cnt_ff == (i_byte_mode_select ? 23 : 49) * P_MCYC_CLKS) else $error("busy span wrong");
  done_ends_busy_a: assert property ($rose(o_done_irq_req) |-> $fell(o_busy))
    else $error("done without busy fall");
  done_busy_excl_a: assert property (o_done_irq_req |-> !o_busy)
    else $error("busy while done");
  sample_len_a: assert property ($rose(o_sample_en) |-> o_sample_en[*8])
    else $error("sample window short");
  pin_idle_zero_a: assert property (!o_sample_en |-> o_analog_pin_sel == 6'h00)
    else $error("pin selected outside sampling");
  pin_onehot_a: assert property (o_sample_en |-> $onehot0(o_analog_pin_sel))
    else $error("several pins selected");
  first_trial_a: assert property ($fell(o_sample_en) && o_busy |-> ##[0:2] o_trial_voltage == 10'h200)
    else $error("first trial not msb");
  abort_power_a: assert property ($rose(i_idle_mode) || $rose(i_power_down) || !o_analog_power_en
    |-> ##[1:2] !o_busy) else $error("conversion not aborted");
  ctrl_read_a: assert property (i_sfr_rd && i_sfr_addr == 8'hc5 |=>
    o_sfr_rdata[4] == $past(o_done_irq_req) && o_sfr_rdata[3] == $past(o_busy)) else $error("status read wrong");
endmodule

bind adcc_top adcc_props #(.P_MCYC_CLKS(P_MCYC_CLKS)) u_props (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sfr_addr(i_sfr_addr), .i_sfr_rd(i_sfr_rd),
  .i_byte_mode_select(i_byte_mode_select), .i_idle_mode(i_idle_mode), .i_power_down(i_power_down),
  .o_sfr_rdata(o_sfr_rdata), .o_analog_pin_sel(o_analog_pin_sel), .o_sample_en(o_sample_en),
  .o_trial_voltage(o_trial_voltage), .o_analog_power_en(o_analog_power_en),
  .o_done_irq_req(o_done_irq_req), .o_busy(o_busy));

`default_nettype wire

// ---- dv/adcc_afe_model.sv ----
/*
  analog front end: mux, sample hold and comparator.
  assumes one 10-bit input code per channel on i_vin.
*/
`timescale 1ns/1ps
`default_nettype none

module adcc_afe_model (
  // clock
  input wire logic        i_mclk,
  // from control, plus the channel input codes on i_vin from the testbench
  input wire logic [5:0]  i_pin_sel,
  input wire logic        i_sample_en,
  input wire logic [9:0]  i_trial_voltage,
  input wire logic        i_power_en,
  input wire logic [59:0] i_vin,
  // to control
  output logic            o_comp_gt
);
  logic [9:0] held_ff = 10'h000;
  logic       junk_ff = 1'b0;

  always_ff @(posedge i_mclk)
  begin
    junk_ff <= ~junk_ff;
    for (int k = 0; k < 6; k++)
      if (i_sample_en && i_pin_sel[k])
        held_ff <= i_vin[k*10 +: 10];
  end

  // strict greater keeps bit; unpowered output is junk
  assign o_comp_gt = i_power_en ? (held_ff > i_trial_voltage) : junk_ff;
endmodule

`default_nettype wire

// ---- dv/tb_sar_adc_conversion_control.sv ----
/*
  random plus corner testbench for adcc_top with analog model.
  assumes a short machine cycle of 2 clocks.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) \
    begin \
      fails++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
    end \
  end

module tb_sar_adc_conversion_control;
  import adcc_pkg::*;
  localparam int P = 2;
  localparam logic [7:0] P_RES = ADCC_ADDR_RES_DFLT;
  logic        mclk, rst_n, wr, rd, byte_m, keep, idle, pd, comp, samp, pwr, done, busy;
  logic [7:0]  addr, wdata, rdata, d, d0;
  logic [5:0]  pin;
  logic [9:0]  trial;
  logic [59:0] vin;
  int          fails = 0;
  int          compares = 0;
  int          seed = 8496;

  adcc_top #(.P_MCYC_CLKS(P)) DUT (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd),
    .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_byte_mode_select(byte_m), .i_idle_keep_alive(keep),
    .i_idle_mode(idle), .i_power_down(pd), .o_analog_pin_sel(pin), .o_sample_en(samp),
    .o_trial_voltage(trial), .i_comp_gt(comp), .o_analog_power_en(pwr), .o_done_irq_req(done),
    .o_busy(busy));
  adcc_afe_model u_afe (.i_mclk(mclk), .i_pin_sel(pin), .i_sample_en(samp), .i_trial_voltage(trial),
    .i_power_en(pwr), .i_vin(vin), .o_comp_gt(comp));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [9:0] sar_exp(input logic [9:0] v, input logic bm);
    logic [9:0] c;
    c = 10'h000;
    for (int b = 9; b >= (bm ? 2 : 0); b--)
    begin
      c[b] = 1'b1;
      if (!(v > c))
        c[b] = 1'b0;
    end
    return c;
  endfunction

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask

  // one conversion; poke sends a second start mid-run
  task automatic conv(input logic [2:0] ch, input logic bm, input int fv, input bit poke);
    logic [9:0] e;
    int         n;
    int         nb;
    byte_m <= bm;
    for (int k = 0; k < 6; k++)
      vin[k*10 +: 10] <= (k == ch && fv >= 0) ? 10'(fv) : 10'($random(seed));
    wr_reg(ADCC_ADDR_CTRL, {2'b00, bm, 2'b01, ch});
    n  = 0;
    nb = 0;
    if (poke)
    begin
      // keep the source bit as written so the status read still matches
      wr_reg(ADCC_ADDR_CTRL, {2'b00, bm, 2'b01, ch ^ 3'h1});
      n = 2;
    end
    while (done !== 1'b1 && n < 200)
    begin
      @(posedge mclk);
      #1;
      n++;
      if (busy === 1'b1 && nb == 0)
        nb = n;
    end
    e = sar_exp(vin[ch*10 +: 10], bm);
    `CHK("conv_cycles", 1'b1, n >= (bm ? 24 : 50) * P + 1 && n <= (bm ? 25 : 51) * P);
    `CHK("busy_rise", 1'b1, nb >= P + 1 && nb <= 2 * P);
    rd_reg(ADCC_ADDR_CTRL, d);
    `CHK("ctrl", {e[1:0], bm, 2'b10, ch}, d);
    rd_reg(P_RES, d);
    `CHK("result", e[9:2], d);
    $display("test conv ch %0d byte %0d done", ch, bm);
  endtask

  task give_verdict;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #500000;
    fails++;
    give_verdict;
  end

  initial
  begin
    rst_n = 1'b0; addr = 8'h00; wr = 1'b0; rd = 1'b0; wdata = 8'h00; byte_m = 1'b0;
    keep = 1'b0; idle = 1'b0; pd = 1'b0; vin = '0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rd_reg(ADCC_ADDR_CTRL, d);
    `CHK("rst_ctrl", 8'h00, d);
    rd_reg(P_RES, d);
    `CHK("rst_res", 8'h00, d);
    rd_reg(8'h00, d);
    `CHK("unmapped", 8'h00, d);
    $display("test reset done");
    for (int i = 0; i < 12; i++)
    begin
      conv(3'(i % 6), i[0], i == 0 ? 0 : (i == 1 ? 1023 : -1), i == 3);
      wr_reg(ADCC_ADDR_CTRL, {5'h00, 3'(i % 6)});
    end
    // done still set: start and channel change refused
    conv(3'h2, 1'b0, -1, 0);
    wr_reg(ADCC_ADDR_CTRL, 8'h1d);
    repeat (4 * P + 2) @(posedge mclk);
    #1;
    `CHK("start_blocked", 1'b0, busy);
    rd_reg(ADCC_ADDR_CTRL, d);
    `CHK("chan_locked", 3'h2, d[2:0]);
    rd_reg(P_RES, d0);
    idle <= 1'b1;
    rd_reg(P_RES, d);
    `CHK("idle_power_off", 1'b0, pwr);
    `CHK("result_kept", d0, d);
    `CHK("done_kept", 1'b1, done);
    idle <= 1'b0;
    wr_reg(ADCC_ADDR_CTRL, 8'h02);
    $display("test blocked start done");
    for (int k = 0; k < 2; k++)
    begin
      keep <= 1'b1;
      wr_reg(ADCC_ADDR_CTRL, 8'h0b);
      repeat (40) @(posedge mclk);
      if (k == 0)
        idle <= 1'b1;
      else
        pd <= 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      `CHK("abort_busy", 1'b0, busy);
      `CHK("abort_done", 1'b0, done);
      `CHK("keep_alive_power", k == 0, pwr);
      idle <= 1'b0;
      pd   <= 1'b0;
      repeat (2 * P) @(posedge mclk);
    end
    $display("test abort done");
    idle <= 1'b1;
    conv(3'h4, 1'b1, -1, 0);
    idle <= 1'b0;
    wr_reg(ADCC_ADDR_CTRL, 8'h04);
    give_verdict;
  end
endmodule

`default_nettype wire
